// *** rtl/ddrio_capture.sv ***
// ddrio_capture: two-edge capture of a pad, realigned to the rising edge
// assumes: pad meets setup and hold around both clock edges
`timescale 1ns/10ps
module ddrio_capture
  import ddrio_pkg::*;
#(
  parameter int WIDTH = DDRIO_WIDTH_DEF
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pad_i,
  output logic      [WIDTH-1:0] rx_high_q,
  output logic      [WIDTH-1:0] rx_low_q
);

  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;

  // half sent while the clock is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rise_q <= {WIDTH{DDRIO_DATA_RST}};
    end else begin
      rise_q <= pad_i;
    end
  end

  // half sent while the clock is high
  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      fall_q <= {WIDTH{DDRIO_DATA_RST}};
    end else begin
      fall_q <= pad_i;
    end
  end

  // both halves moved onto the rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_high_q <= {WIDTH{DDRIO_DATA_RST}};
      rx_low_q  <= {WIDTH{DDRIO_DATA_RST}};
    end else begin
      rx_high_q <= rise_q;
      rx_low_q  <= fall_q;
    end
  end

  AST_RISE_CAPTURE: assert property (
    @(posedge clk) disable iff (reset)
    $past(reset) == 1'b0 |-> rise_q == $past(pad_i))
    else $error("rising capture missed the pad value");

  AST_FALL_CAPTURE: assert property (
    @(negedge clk) disable iff (reset)
    $past(reset) == 1'b0 |-> fall_q == $past(pad_i))
    else $error("falling capture missed the pad value");

  AST_REALIGN: assert property (
    @(posedge clk) disable iff (reset)
    $past(reset) == 1'b0 && $past(reset, 2) == 1'b0
      |-> rx_high_q == $past(pad_i, DDRIO_RX_LAT)
      && rx_low_q == $past(fall_q))
    else $error("realigned halves do not follow the captures");

endmodule

// *** rtl/ddrio_pkg.sv ***
// ddrio_pkg: constants shared by the double data rate pin logic
// assumes: one common clock, asynchronous active-high reset
package ddrio_pkg;

  // default width of each pin group
  localparam int DDRIO_WIDTH_DEF = 1;

  // values after reset
  localparam logic DDRIO_DATA_RST = 1'h0;
  localparam logic DDRIO_OE_RST   = 1'h0;

  // rising-edge cycles from a pad sample to the realigned output
  localparam int DDRIO_RX_LAT = 2;

endpackage

// *** rtl/ddrio_top.sv ***
// ddrio_top: double data rate input, output and bidirectional pin logic
// assumes: pins are resolved outside from the output and enable signals
//
// Operation
// - rising edge register captures the input pad
// - falling edge register captures the input pad
// - both halves re-registered on the rising edge
// - two output streams held in clocked registers
// - clock level selects between the output registers
// - high phase drives high register, low drives low
// - bidirectional pin combines capture and output paths
// - bidirectional pin driven only while enable set
`timescale 1ns/10ps
module ddrio_top
  import ddrio_pkg::*;
#(
  parameter int WIDTH = DDRIO_WIDTH_DEF
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] DIN_PAD,
  output logic      [WIDTH-1:0] RX_HIGH,
  output logic      [WIDTH-1:0] RX_LOW,
  input  wire logic [WIDTH-1:0] TX_HIGH,
  input  wire logic [WIDTH-1:0] TX_LOW,
  output logic      [WIDTH-1:0] DOUT_PAD,
  input  wire logic [WIDTH-1:0] BIDI_I,
  output logic      [WIDTH-1:0] BIDI_O,
  output logic                  BIDI_OE,
  input  wire logic [WIDTH-1:0] BIDI_TX_HIGH,
  input  wire logic [WIDTH-1:0] BIDI_TX_LOW,
  input  wire logic             BIDI_TX_OE,
  output logic      [WIDTH-1:0] BIDI_RX_HIGH,
  output logic      [WIDTH-1:0] BIDI_RX_LOW
);

  logic [WIDTH-1:0] tx_h_q;
  logic [WIDTH-1:0] tx_l_q;
  logic [WIDTH-1:0] btx_h_q;
  logic [WIDTH-1:0] btx_l_q;
  logic             oe_q;

  // input-only pad
  ddrio_capture #(
    .WIDTH     (WIDTH)
  ) u_rx (
    .clk       (CLK),
    .reset     (RESET),
    .pad_i     (DIN_PAD),
    .rx_high_q (RX_HIGH),
    .rx_low_q  (RX_LOW)
  );

  // bidirectional pad, capture side
  ddrio_capture #(
    .WIDTH     (WIDTH)
  ) u_brx (
    .clk       (CLK),
    .reset     (RESET),
    .pad_i     (BIDI_I),
    .rx_high_q (BIDI_RX_HIGH),
    .rx_low_q  (BIDI_RX_LOW)
  );

  // output-only stream registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tx_h_q <= {WIDTH{DDRIO_DATA_RST}};
      tx_l_q <= {WIDTH{DDRIO_DATA_RST}};
    end else begin
      tx_h_q <= TX_HIGH;
      tx_l_q <= TX_LOW;
    end
  end

  // bidirectional stream registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      btx_h_q <= {WIDTH{DDRIO_DATA_RST}};
      btx_l_q <= {WIDTH{DDRIO_DATA_RST}};
    end else begin
      btx_h_q <= BIDI_TX_HIGH;
      btx_l_q <= BIDI_TX_LOW;
    end
  end

  // tri-state control
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      oe_q <= DDRIO_OE_RST;
    end else begin
      oe_q <= BIDI_TX_OE;
    end
  end

  // clock-phase multiplexers
  assign DOUT_PAD = CLK ? tx_h_q : tx_l_q;
  assign BIDI_O   = CLK ? btx_h_q : btx_l_q;
  assign BIDI_OE  = oe_q;

  AST_OUT_LOW_PHASE: assert property (
    @(posedge CLK) disable iff (RESET)
    DOUT_PAD == tx_l_q && BIDI_O == btx_l_q)
    else $error("low clock phase did not drive the low register");

  AST_OUT_HIGH_PHASE: assert property (
    @(negedge CLK) disable iff (RESET)
    DOUT_PAD == tx_h_q && BIDI_O == btx_h_q)
    else $error("high clock phase did not drive the high register");

  AST_OUT_STREAMS: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> tx_h_q == $past(TX_HIGH)
      && tx_l_q == $past(TX_LOW))
    else $error("output registers did not take the streams");

  AST_OE_REG: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> BIDI_OE == $past(BIDI_TX_OE))
    else $error("output enable not one cycle behind its request");

  AST_OE_HOLD: assert property (
    @(posedge CLK) disable iff (RESET)
    !BIDI_TX_OE ##1 !BIDI_TX_OE |-> !BIDI_OE ##1 !BIDI_OE)
    else $error("pin driven while enable withdrawn");

  AST_BIDI_RX: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 && $past(RESET, 2) == 1'b0
      |-> BIDI_RX_HIGH == $past(BIDI_I, 2))
    else $error("bidirectional capture does not follow the pad");

  AST_RX_HIGH: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 && $past(RESET, 2) == 1'b0
      |-> RX_HIGH == $past(DIN_PAD, 2))
    else $error("input high half wrong");

  AST_OUT_DELAY: assert property (
    @(negedge CLK) disable iff (RESET)
    DOUT_PAD == TX_HIGH || $past(TX_HIGH) == tx_h_q)
    else $error("high register not shown in high phase");

  // pad multiplexers against the streams taken one edge before
  AST_OUT_LOW_DELAY: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> DOUT_PAD == $past(TX_LOW))
    else $error("low register not shown in low phase");

  AST_BIDI_LOW_DELAY: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> BIDI_O == $past(BIDI_TX_LOW))
    else $error("bidirectional low half not shown in low phase");

  AST_BIDI_HIGH_DELAY: assert property (
    @(negedge CLK) disable iff (RESET)
    BIDI_O == BIDI_TX_HIGH || $past(BIDI_TX_HIGH) == btx_h_q)
    else $error("bidirectional high half not shown in high phase");

  AST_BIDI_STREAMS: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> btx_h_q == $past(BIDI_TX_HIGH)
      && btx_l_q == $past(BIDI_TX_LOW))
    else $error("bidirectional registers did not take the streams");

  // capture paths: low half seen at the falling edge before
  AST_RX_LOW: assert property (
    @(negedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> RX_LOW == $past(DIN_PAD))
    else $error("input low half wrong");

  AST_BIDI_RX_LOW: assert property (
    @(negedge CLK) disable iff (RESET)
    $past(RESET) == 1'b0 |-> BIDI_RX_LOW == $past(BIDI_I))
    else $error("bidirectional low half wrong");

  // enable edges follow the request by one rising edge
  AST_OE_ROSE: assert property (
    @(posedge CLK) disable iff (RESET)
    $rose(BIDI_OE) |-> $past(BIDI_TX_OE))
    else $error("pin drive started without a request");

  AST_OE_FELL: assert property (
    @(posedge CLK) disable iff (RESET)
    $fell(BIDI_OE) |-> !$past(BIDI_TX_OE))
    else $error("pin drive stopped while still requested");

  AST_OE_DRIVE: assert property (
    @(posedge CLK) disable iff (RESET)
    BIDI_TX_OE ##1 BIDI_TX_OE |-> BIDI_OE ##1 BIDI_OE)
    else $error("pin released while enable requested");

  AST_OE_STAYS_OFF: assert property (
    @(posedge CLK) disable iff (RESET)
    !BIDI_OE && !BIDI_TX_OE |=> !BIDI_OE)
    else $error("pin driven without a request");

  AST_OE_STAYS_ON: assert property (
    @(posedge CLK) disable iff (RESET)
    BIDI_OE && BIDI_TX_OE |=> BIDI_OE)
    else $error("pin drive dropped while requested");

  // state left by reset at the first rising edge after release
  AST_OE_AFTER_RESET: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> BIDI_OE == DDRIO_OE_RST)
    else $error("pin driven straight after reset");

  AST_OUT_AFTER_RESET: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> DOUT_PAD == {WIDTH{DDRIO_DATA_RST}}
      && BIDI_O == {WIDTH{DDRIO_DATA_RST}})
    else $error("output pads not at reset value after release");

  AST_RX_AFTER_RESET: assert property (
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> RX_HIGH == {WIDTH{DDRIO_DATA_RST}}
      && RX_LOW == {WIDTH{DDRIO_DATA_RST}}
      && BIDI_RX_HIGH == {WIDTH{DDRIO_DATA_RST}}
      && BIDI_RX_LOW == {WIDTH{DDRIO_DATA_RST}})
    else $error("captured halves not at reset value after release");

endmodule

// *** testbench/ddrio_peer.sv ***
// ddrio_peer: far-side ddr transmitter driving one pad
// assumes: new pair given just after each rising edge
`timescale 1ns/10ps
module ddrio_peer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] hi,
  input  wire logic [W-1:0] lo,
  input  wire logic         oe,
  input  wire logic [W-1:0] o,
  output logic      [W-1:0] pad
);
  logic [W-1:0] l_q;
  logic [W-1:0] p;
  // high half set in the low phase, low half in the high phase
  always @(clk) begin
    #2;
    if (clk) begin
      p = l_q;
    end else begin
      p = hi;
      l_q = lo;
    end
  end
  // peer lets go of the pin while the device drives it
  assign #1 pad = oe ? o : p;
endmodule

// *** testbench/ddrio_top_bench.sv ***
// ddrio_top_bench: random ddr traffic on all three pad paths
// assumes: peers model the wire; expectations queued per cycle
`timescale 1ns/10ps
module ddrio_top_bench;
  import ddrio_pkg::*;
  localparam int W = 4;
  logic CLK = 0, RESET = 1, oe = 0, poe = 0, boe;
  logic [W-1:0] a = 0, b = 0, c = 0, d = 0, e = 0, f = 0, pf = 0;
  logic [W-1:0] rxh, rxl, brh, brl, dout, bo, din, bi;
  logic [15:0] rq[$];
  logic [16:0] tq[$];
  logic [15:0] r;
  logic [16:0] t;
  logic [31:0] rnd;
  int miscompares = 0, check_count = 0, seed = 76942;
  bit done = 0;
  always #25 CLK = ~CLK;
  ddrio_top #(.WIDTH(W)) dut (.CLK(CLK), .RESET(RESET), .DIN_PAD(din),
    .RX_HIGH(rxh), .RX_LOW(rxl), .TX_HIGH(c), .TX_LOW(d),
    .DOUT_PAD(dout), .BIDI_I(bi), .BIDI_O(bo), .BIDI_OE(boe),
    .BIDI_TX_HIGH(e), .BIDI_TX_LOW(f), .BIDI_TX_OE(oe),
    .BIDI_RX_HIGH(brh), .BIDI_RX_LOW(brl));
  ddrio_peer #(.W(W)) peer_in (.clk(CLK), .hi(a), .lo(b),
    .oe(1'h0), .o(4'h0), .pad(din));
  ddrio_peer #(.W(W)) peer_io (.clk(CLK), .hi(~a), .lo(~b),
    .oe(boe), .o(bo), .pad(bi));
  task automatic cmp(input logic [W-1:0] got, input logic [W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t pad value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_drv(input logic [W-1:0] got, input logic [W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t driven pad %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    #1;
    cmp_drv(dout, 4'h0);
    cmp_drv(bo, 4'h0);
    cmp_drv({3'h0, boe}, 4'h0);
    cmp(rxh, 4'h0);
    cmp(rxl, 4'h0);
    cmp(brh, 4'h0);
    cmp(brl, 4'h0);
    RESET = 0;
    repeat (400) begin
      @(posedge CLK);
      #1;
      poe = oe;
      pf = f;
      rnd = $random(seed);
      {a, b, c, d, e, f, oe} = rnd[24:0];
      rq.push_back({a, b, poe ? pf : ~a, oe ? e : ~b});
      tq.push_back({c, d, e, oe, f});
    end
    done = 1;
    repeat (3) @(posedge CLK);
    finish_test();
  end
  // capture side: result two rising edges after the pair
  always @(negedge CLK) if (rq.size() > 2 || (done && rq.size() > 0)) begin
    r = rq.pop_front();
    cmp(rxh, r[15:12]);
    cmp(rxl, r[11:8]);
    cmp(brh, r[7:4]);
    cmp(brl, r[3:0]);
  end
  // drive side: high phase then low phase of the next cycle
  always @(posedge CLK) if (tq.size() > 0) begin
    t = tq.pop_front();
    #12;
    cmp_drv(dout, t[16:13]);
    cmp_drv(bo, t[8:5]);
    cmp_drv({3'h0, boe}, {3'h0, t[4]});
    #25;
    cmp_drv(dout, t[12:9]);
    cmp_drv(bo, t[3:0]);
    if (t[4]) cmp_drv(bi, t[3:0]);
  end
endmodule
